/* design/mem_bus_pkg.sv */
/*
 Constants for the memory bus slave: register offsets, field positions,
 reset values, cycle-type codes and timing figures.
 Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package mem_bus_pkg;
   // ************************************************************
   // Widths
   // ************************************************************
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int AXI_AW = 8;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [AXI_AW-1:0] OFF_CONFIG = 8'h00;
   localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h04;
   localparam logic [AXI_AW-1:0] OFF_ADDR = 8'h08;
   localparam logic [AXI_AW-1:0] OFF_WDATA = 8'h0c;
   // ************************************************************
   // Configuration fields
   // ************************************************************
   localparam int CFG_MOS_BIT = 0;
   localparam int CFG_BLOCK_LSB = 1;
   localparam int CFG_BLOCK_W = 5;
   localparam int CFG_MODEN_LSB = 6;
   localparam int CFG_MODEN_W = 4;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   // ************************************************************
   // Status fields
   // ************************************************************
   localparam int ST_REQ_BIT = 0;
   localparam int ST_SSYNC_BIT = 1;
   localparam int ST_READ_BIT = 2;
   localparam int ST_CLEAR_BIT = 3;
   localparam int ST_CTYPE_LSB = 4;
   localparam int ST_BYTE_BIT = 6;
   // ************************************************************
   // Cycle types and bus responses
   // ************************************************************
   localparam logic [1:0] CT_WORD_READ = 2'h0;
   localparam logic [1:0] CT_READ_PAUSE = 2'h1;
   localparam logic [1:0] CT_WORD_WRITE = 2'h2;
   localparam logic [1:0] CT_BYTE_WRITE = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int MASTER_SYNC_IN_DELAY_NS = 150;
   localparam int MASTER_SYNC_IN_DELAY_CYC = (MASTER_SYNC_IN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* design/decode_if.sv */
/*
 Carrier between the slave and its address decoder.
 Assumes both ends run combinationally in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
   import mem_bus_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic mosMode;
   logic [CFG_BLOCK_W-1:0] blockStraps;
   logic [CFG_MODEN_W-1:0] moduleEnables;
   logic hit;
   logic [1:0] moduleSelect;
   modport slave (output addr, mosMode, blockStraps, moduleEnables, input hit, moduleSelect);
   modport decoder (input addr, mosMode, blockStraps, moduleEnables, output hit, moduleSelect);
endinterface
`default_nettype wire

/* design/addr_match.sv */
/*
 Address-match decoder: block compare against the straps and module select.
 Assumes the address is already active high and stable while it is used.
*/
`timescale 1ns/1ps
`default_nettype none
module addr_match
   import mem_bus_pkg::*;
(
   decode_if.decoder dec
);
   // ************************************************************
   // Module select
   // ************************************************************
   function automatic logic [1:0] modSel(input logic [ADDR_W-1:0] a, input logic mos);
      // R1: bipolar uses bits 12..11.
      // R2: MOS uses bits 14..13.
      modSel = mos ? a[14:13] : a[12:11];
   endfunction

   logic blockOk;
   logic highOk;
   logic lowOk;

   always_comb
   begin
      // R6: cut strap needs a one, intact strap a zero.
      highOk = (dec.addr[17:15] == dec.blockStraps[4:2]);
      // R4: MOS forces the bit 14..13 compare to pass.
      lowOk = dec.mosMode || (dec.addr[14:13] == dec.blockStraps[1:0]);
      // R5: bits 17..15 plus type-selected 14..13 against block straps.
      blockOk = highOk && lowOk;
   end

   assign dec.moduleSelect = modSel(dec.addr, dec.mosMode);
   // R3: answer only where the matching module strap is removed.
   assign dec.hit = blockOk && dec.moduleEnables[dec.moduleSelect];
endmodule // addr_match
`default_nettype wire

/* design/mem_bus_slave.sv */
/*
 System-bus slave interface of the memory controller with strap registers
 reached over AXI4-Lite.
 Assumes bus pins are synchronous to clk and the memory side acknowledges.
*/
// Operation
// R1: Bipolar module select uses address bits 11 and 12.
// R2: MOS module select uses address bits 13 and 14.
// R3: Answer a module code only when its module-enable strap is removed.
// R4: In MOS mode the bit 13-14 block compare always passes.
// R5: Compare bits 15-17 and selected 13-14 against the block straps.
// R6: Removed block strap needs address bit one, intact needs zero.
// R7: Matching address with master sync raises the bus cycle request.
// R8: Invert the 18 active-low address lines into the address latch.
// R9: Invert the 16 active-low data lines for the write data path.
// R10: Drive read data open-collector only under slave sync on reads.
// R11: Assert slave sync on reads only once data is stable.
// R12: Buffer master sync and keep both polarities internally.
// R13: Internal cycle bit one stays inactive until master sync arrives.
// R14: Provide true and complement versions of both cycle-type lines.
// R15: Cycle code selects word read, read pause, word write, byte write.
// R16: Clear on power low, or on initialize without refresh activity.
// R17: Refresh suppresses initialize clear but never power-low clear.
// R18: The clear resets all condition-sensitive control logic.
// R19: Ignore cycles outside every enabled range.
`timescale 1ns/1ps
`default_nettype none
module mem_bus_slave
   import mem_bus_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [mem_bus_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [mem_bus_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [mem_bus_pkg::ADDR_W-1:0] addrInN,
   input wire logic [mem_bus_pkg::DATA_W-1:0] dataInN,
   output logic [mem_bus_pkg::DATA_W-1:0] dataOut,
   output logic [mem_bus_pkg::DATA_W-1:0] dataOe,
   input wire logic masterSyncInN,
   input wire logic cycleType0N,
   input wire logic cycleType1N,
   input wire logic busInitN,
   input wire logic memoryPowerLowN,
   output logic slaveSyncOutN,
   input wire logic refreshRequest,
   input wire logic refreshGrant,
   input wire logic memoryAck,
   input wire logic [mem_bus_pkg::DATA_W-1:0] readDataWord,
   output logic busCycleRequest,
   output logic [mem_bus_pkg::ADDR_W-1:0] memoryAddressLatch,
   output logic [mem_bus_pkg::DATA_W-1:0] writeData,
   output logic byteWrite,
   output logic readCycle,
   output logic controllerClear
);
   import mem_bus_pkg::*;

   typedef enum logic [1:0] {IDLE, ACCESS, RESPOND} state_e;

   // ************************************************************
   // Pin receivers
   // ************************************************************
   logic masterSyncH_q;
   logic masterSyncL_q;
   logic cycle0H;
   logic cycle0L;
   logic cycle1H;
   logic cycle1L;
   logic internalCycleBit1;
   logic clear_d;
   logic controllerClear_q;

   // R12: both polarities of master sync.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         masterSyncH_q <= 1'b0;
         masterSyncL_q <= 1'b1;
      end
      else
      begin
         masterSyncH_q <= ~masterSyncInN;
         masterSyncL_q <= masterSyncInN;
      end
   end

   always_comb
   begin
      // R14: low-true follow the lines, high-true are complements.
      cycle0L = cycleType0N;
      cycle0H = ~cycleType0N;
      cycle1L = cycleType1N;
      cycle1H = ~cycleType1N;
      // R13: bit one inactive until master sync.
      internalCycleBit1 = masterSyncH_q & cycle1H;
      // R16: power low, or initialize with no refresh activity.
      // R17: refresh blocks only the initialize term.
      clear_d = ~memoryPowerLowN | (~busInitN & ~refreshRequest & ~refreshGrant);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         controllerClear_q <= 1'b1;
      else
         controllerClear_q <= clear_d;
   end

   // ************************************************************
   // Configuration register
   // ************************************************************
   logic [31:0] config_q;
   decode_if dec ();

   assign dec.addr = ~addrInN;
   assign dec.mosMode = config_q[CFG_MOS_BIT];
   assign dec.blockStraps = config_q[CFG_BLOCK_LSB +: CFG_BLOCK_W];
   assign dec.moduleEnables = config_q[CFG_MODEN_LSB +: CFG_MODEN_W];

   addr_match u_match (
      .dec(dec)
   );

   // ************************************************************
   // Bus cycle control
   // ************************************************************
   state_e state_q;
   logic busCycleRequest_q;
   logic slaveSyncOutN_q;
   logic [DATA_W-1:0] dataOe_q;
   logic [ADDR_W-1:0] memoryAddressLatch_q;
   logic [DATA_W-1:0] writeData_q;
   logic [1:0] cycleType_q;

   // R18: the clear returns all cycle control to idle.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= IDLE;
         busCycleRequest_q <= 1'b0;
         slaveSyncOutN_q <= 1'b1;
         dataOe_q <= '0;
      end
      else if (controllerClear_q)
      begin
         state_q <= IDLE;
         busCycleRequest_q <= 1'b0;
         slaveSyncOutN_q <= 1'b1;
         dataOe_q <= '0;
      end
      else
      begin
         case (state_q)
            IDLE:
            begin
               // R7: matching address and master sync raise the request.
               // R19: a miss leaves the bus untouched.
               if (masterSyncH_q && dec.hit)
               begin
                  busCycleRequest_q <= 1'b1;
                  state_q <= ACCESS;
               end
            end
            ACCESS:
            begin
               if (!masterSyncH_q)
               begin
                  busCycleRequest_q <= 1'b0;
                  state_q <= IDLE;
               end
               // R11: slave sync waits for stable data.
               else if (memoryAck)
               begin
                  busCycleRequest_q <= 1'b0;
                  slaveSyncOutN_q <= 1'b0;
                  // R10: pull low the lines of one bits on reads only.
                  if (!cycleType_q[1])
                     dataOe_q <= readDataWord;
                  state_q <= RESPOND;
               end
            end
            RESPOND:
            begin
               if (masterSyncL_q)
               begin
                  slaveSyncOutN_q <= 1'b1;
                  dataOe_q <= '0;
                  state_q <= IDLE;
               end
            end
            default:
               state_q <= IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         memoryAddressLatch_q <= '0;
         writeData_q <= '0;
         cycleType_q <= CT_WORD_READ;
      end
      else if (state_q == IDLE && masterSyncH_q && dec.hit && !controllerClear_q)
      begin
         // R8: inverted address into the latch.
         memoryAddressLatch_q <= dec.addr;
         // R9: inverted data for the write path.
         writeData_q <= ~dataInN;
         // R15: latch the cycle code.
         cycleType_q <= {internalCycleBit1, cycle0H};
      end
   end

   // ************************************************************
   // Register bus slave
   // ************************************************************
   logic awHeld_q;
   logic wHeld_q;
   logic [AXI_AW-1:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic [31:0] readMux;
   logic readOk;

   function automatic logic [AXI_AW-1:0] wordOf(input logic [AXI_AW-1:0] a);
      wordOf = {a[AXI_AW-1:2], 2'h0};
   endfunction

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= '0;
         wData_q <= '0;
         wStrb_q <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         config_q <= CONFIG_RESET;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (awHeld_q && wHeld_q && !s_axi_bvalid)
         begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (wordOf(awAddr_q) == OFF_CONFIG)
            begin
               s_axi_bresp <= RESP_OKAY;
               for (int i = 0; i < 4; i++)
               begin
                  if (wStrb_q[i])
                     config_q[i*8 +: 8] <= wData_q[i*8 +: 8];
               end
            end
            else if (wordOf(awAddr_q) == OFF_STATUS || wordOf(awAddr_q) == OFF_ADDR
                     || wordOf(awAddr_q) == OFF_WDATA)
               s_axi_bresp <= RESP_OKAY;
            else
               s_axi_bresp <= RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   assign s_axi_awready = !awHeld_q;
   assign s_axi_wready = !wHeld_q;

   always_comb
   begin
      readOk = 1'b1;
      readMux = '0;
      if (wordOf(s_axi_araddr) == OFF_CONFIG)
         readMux = config_q & 32'h0000_03ff;
      else if (wordOf(s_axi_araddr) == OFF_STATUS)
      begin
         readMux[ST_REQ_BIT] = busCycleRequest_q;
         readMux[ST_SSYNC_BIT] = ~slaveSyncOutN_q;
         readMux[ST_READ_BIT] = (state_q != IDLE) && !cycleType_q[1];
         readMux[ST_CLEAR_BIT] = controllerClear_q;
         readMux[ST_CTYPE_LSB +: 2] = cycleType_q;
         readMux[ST_BYTE_BIT] = (cycleType_q == CT_BYTE_WRITE);
      end
      else if (wordOf(s_axi_araddr) == OFF_ADDR)
         readMux = {14'h0000, memoryAddressLatch_q};
      else if (wordOf(s_axi_araddr) == OFF_WDATA)
         readMux = {16'h0000, writeData_q};
      else
         readOk = 1'b0;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= readMux;
         s_axi_rresp <= readOk ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   assign s_axi_arready = !s_axi_rvalid;

   // ************************************************************
   // Outputs
   // ************************************************************
   assign busCycleRequest = busCycleRequest_q;
   assign slaveSyncOutN = slaveSyncOutN_q;
   assign dataOe = dataOe_q;
   assign dataOut = '0;
   assign memoryAddressLatch = memoryAddressLatch_q;
   assign writeData = writeData_q;
   assign byteWrite = (cycleType_q == CT_BYTE_WRITE);
   assign readCycle = !cycleType_q[1];
   assign controllerClear = controllerClear_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   property p_reqCause;
      @(posedge clk) disable iff (!rstn) $rose(busCycleRequest_q) |-> $past(masterSyncH_q && dec.hit);
   endproperty
   a_reqCause: assert property (p_reqCause) else $error("Request without hit and master sync."); // R7

   property p_missIgnored;
      @(posedge clk) disable iff (!rstn) (state_q == IDLE && !dec.hit) |=> !busCycleRequest_q && slaveSyncOutN_q;
   endproperty
   a_missIgnored: assert property (p_missIgnored) else $error("Answered a missed address."); // R19

   property p_driveOnRead;
      @(posedge clk) disable iff (!rstn) (dataOe_q != '0) |-> !slaveSyncOutN_q && !cycleType_q[1];
   endproperty
   a_driveOnRead: assert property (p_driveOnRead) else $error("Data driven outside a read response."); // R10

   property p_ssyncAfterAck;
      @(posedge clk) disable iff (!rstn) $fell(slaveSyncOutN_q) |-> $past(memoryAck) && $past(state_q == ACCESS);
   endproperty
   a_ssyncAfterAck: assert property (p_ssyncAfterAck) else $error("Slave sync before stable data."); // R11

   property p_addrLatch;
      @(posedge clk) disable iff (!rstn) $rose(busCycleRequest_q) |-> memoryAddressLatch_q == $past(~addrInN);
   endproperty
   a_addrLatch: assert property (p_addrLatch) else $error("Address latch not the inverted lines."); // R8

   property p_writeData;
      @(posedge clk) disable iff (!rstn) $rose(busCycleRequest_q) |-> writeData_q == $past(~dataInN);
   endproperty
   a_writeData: assert property (p_writeData) else $error("Write data not the inverted lines."); // R9

   property p_bit1Held;
      @(posedge clk) disable iff (!rstn) !masterSyncH_q |-> !internalCycleBit1;
   endproperty
   a_bit1Held: assert property (p_bit1Held) else $error("Cycle bit one active before master sync."); // R13

   property p_syncPolarity;
      @(posedge clk) disable iff (!rstn) ##1 (masterSyncH_q != masterSyncL_q) && masterSyncH_q == $past(~masterSyncInN);
   endproperty
   a_syncPolarity: assert property (p_syncPolarity) else $error("Master sync polarities disagree."); // R12

   property p_powerClear;
      @(posedge clk) disable iff (!rstn) !memoryPowerLowN |=> controllerClear_q ##1 state_q == IDLE;
   endproperty
   a_powerClear: assert property (p_powerClear) else $error("Power low did not clear."); // R16

   property p_refreshBlocks;
      @(posedge clk) disable iff (!rstn) (memoryPowerLowN && (refreshRequest || refreshGrant)) |=> !controllerClear_q;
   endproperty
   a_refreshBlocks: assert property (p_refreshBlocks) else $error("Initialize clear during refresh."); // R17

   property p_clearIdles;
      @(posedge clk) disable iff (!rstn) controllerClear_q |=> state_q == IDLE && slaveSyncOutN_q && !busCycleRequest_q;
   endproperty
   a_clearIdles: assert property (p_clearIdles) else $error("Clear left control active."); // R18

   property p_bHold;
      @(posedge clk) disable iff (!rstn) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bHold: assert property (p_bHold) else $error("Write response dropped early.");

   c_readCycle: cover property (@(posedge clk) disable iff (!rstn) $fell(slaveSyncOutN_q) && !cycleType_q[1]);
   c_byteWrite: cover property (@(posedge clk) disable iff (!rstn) $fell(slaveSyncOutN_q) && cycleType_q == CT_BYTE_WRITE);
   c_abort: cover property (@(posedge clk) disable iff (!rstn) state_q == ACCESS && !masterSyncH_q);
   c_initClear: cover property (@(posedge clk) disable iff (!rstn) memoryPowerLowN && $rose(controllerClear_q));
endmodule // mem_bus_slave
`default_nettype wire

/* dv/bus_master_model.sv */
/*
 Bus master model: drives address, data, cycle-type and master sync lines.
 Assumes open-collector data lines that float high when nobody pulls them.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_master_model
   import mem_bus_pkg::*;
(
   input wire logic clk,
   input wire logic [mem_bus_pkg::DATA_W-1:0] dataOe,
   output logic [mem_bus_pkg::ADDR_W-1:0] addrInN,
   output logic [mem_bus_pkg::DATA_W-1:0] dataInN,
   output logic masterSyncInN,
   output logic cycleType0N,
   output logic cycleType1N
);
   logic [DATA_W-1:0] driveN = '1;
   // The wired data line is low where either party pulls it.
   assign dataInN = driveN & ~dataOe;
   initial
   begin
      addrInN = '1;
      masterSyncInN = 1'b1;
      {cycleType1N, cycleType0N} = 2'h3;
   end
   task automatic start(input logic [ADDR_W-1:0] a, input logic [1:0] code, input logic [DATA_W-1:0] d);
      @(posedge clk);
      addrInN <= ~a;
      {cycleType1N, cycleType0N} <= ~code;
      driveN <= code[1] ? ~d : '1;
      repeat (MASTER_SYNC_IN_DELAY_CYC) @(posedge clk);
      masterSyncInN <= 1'b0;
   endtask
   task automatic stop();
      @(posedge clk);
      masterSyncInN <= 1'b1;
      @(posedge clk);
      addrInN <= '1;
      driveN <= '1;
      {cycleType1N, cycleType0N} <= 2'h3;
   endtask
endmodule // bus_master_model
`default_nettype wire

/* dv/memory_bus_slave_decode_interface_tb_top.sv */
/*
 Testbench for the memory bus slave: registers, decode, bus cycles, clear.
 Assumes the bus master model beside it; memory acknowledges come from here.
*/
`timescale 1ns/1ps
`default_nettype none
module memory_bus_slave_decode_interface_tb_top;
   import mem_bus_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [ADDR_W-1:0] addrInN, memoryAddressLatch;
   logic [DATA_W-1:0] dataInN, dataOut, dataOe, writeData, readDataWord = '0;
   logic masterSyncInN, cycleType0N, cycleType1N, slaveSyncOutN, busCycleRequest, byteWrite, readCycle;
   logic controllerClear, busInitN = 1'b1, memoryPowerLowN = 1'b1;
   logic refreshRequest = 1'b0, refreshGrant = 1'b0, memoryAck = 1'b0;
   logic [4:0] clrTab [5] = '{5'h0b, 5'h14, 5'h12, 5'h11, 5'h18};
   int err_total = 0;
   int comparisons = 0;
   mem_bus_slave uut
   (
      .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .addrInN, .dataInN, .dataOut, .dataOe,
      .masterSyncInN, .cycleType0N, .cycleType1N, .busInitN, .memoryPowerLowN, .slaveSyncOutN, .refreshRequest,
      .refreshGrant, .memoryAck, .readDataWord, .busCycleRequest, .memoryAddressLatch, .writeData, .byteWrite,
      .readCycle, .controllerClear
   );
   bus_master_model model
   (
      .clk, .dataOe, .addrInN, .dataInN, .masterSyncInN, .cycleType0N, .cycleType1N
   );
   initial
   begin
      forever #5 clk = ~clk;
   end
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic bus_cycle(input logic [ADDR_W-1:0] a, input logic [1:0] code, input logic [DATA_W-1:0] d,
      input logic hit);
      model.start(a, code, d);
      repeat (3) @(posedge clk);
      #1;
      check("request", hit, busCycleRequest);
      check("early sync", 1'b1, slaveSyncOutN);
      if (hit)
      begin
         check("latch", a, memoryAddressLatch);
         check("read", !code[1], readCycle);
         check("byte", code == CT_BYTE_WRITE, byteWrite);
         if (code[1]) check("wdata", d, writeData);
         axi_read(OFF_STATUS, rd, rsp);
         check("status", {25'h0, code == CT_BYTE_WRITE, code, 1'b0, !code[1], 2'b01}, rd);
         axi_read(OFF_ADDR, rd, rsp);
         check("addr reg", a, rd);
         @(posedge clk);
         memoryAck <= 1'b1;
         readDataWord <= d;
         @(posedge clk);
         memoryAck <= 1'b0;
         repeat (2) @(posedge clk);
         #1;
         check("ack sync", 1'b0, slaveSyncOutN);
         check("drive", code[1] ? 16'h0 : d, dataOe);
         check("wire", d ^ 16'hffff, dataInN);
         check("req drop", 1'b0, busCycleRequest);
         check("level", 16'h0, dataOut);
      end
      else
      begin
         repeat (4) @(posedge clk);
         #1;
         check("miss sync", 1'b1, slaveSyncOutN);
      end
      model.stop();
      repeat (3) @(posedge clk);
      #1;
      check("end sync", 1'b1, slaveSyncOutN);
      check("end drive", 16'h0, dataOe);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ************************************************************
   // Tests
   // ************************************************************
   initial
   begin
      repeat (2) @(posedge clk);
      check("clear in reset", 1'b1, controllerClear);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      axi_read(OFF_CONFIG, rd, rsp);
      check("config reset", CONFIG_RESET, rd);
      axi_write(OFF_CONFIG, {22'h0, 4'b0101, 5'b10010, 1'b0}, rsp);
      check("write resp", RESP_OKAY, rsp);
      axi_read(OFF_CONFIG, rd, rsp);
      check("config", {22'h0, 4'b0101, 5'b10010, 1'b0}, rd);
      axi_read(8'h40, rd, rsp);
      check("unmapped resp", RESP_SLVERR, rsp);
      check("unmapped data", 32'h0, rd);
      $display("test registers done");
      for (int c = 0; c < 4; c++)
         bus_cycle(18'h24123 + 18'(c), 2'(c), 16'ha5c3 ^ 16'(c), 1'b1);
      bus_cycle(18'h25456, CT_WORD_READ, 16'h1234, 1'b1);
      bus_cycle(18'h24800, CT_WORD_READ, 16'h1234, 1'b0);
      bus_cycle(18'h04123, CT_WORD_WRITE, 16'h1234, 1'b0);
      bus_cycle(18'h26000, CT_WORD_WRITE, 16'h1234, 1'b0);
      model.start(18'h24123, CT_WORD_READ, 16'h0);
      repeat (3) @(posedge clk);
      #1;
      check("abort req", 1'b1, busCycleRequest);
      model.stop();
      repeat (2) @(posedge clk);
      #1;
      check("abort", 32'h1, {busCycleRequest, slaveSyncOutN});
      $display("test bipolar decode done");
      axi_write(OFF_CONFIG, {22'h0, 4'b0010, 5'b10000, 1'b1}, rsp);
      bus_cycle(18'h23800, CT_READ_PAUSE, 16'h0f0f, 1'b1);
      bus_cycle(18'h20000, CT_READ_PAUSE, 16'h0f0f, 1'b0);
      $display("test mos decode done");
      foreach (clrTab[i])
      begin
         @(posedge clk);
         {memoryPowerLowN, busInitN, refreshRequest, refreshGrant} <= clrTab[i][4:1];
         repeat (2) @(posedge clk);
         #1;
         check("clear", clrTab[i][0], controllerClear);
      end
      $display("test clear done");
      print_verdict();
   end
   initial
   begin
      #200000;
      err_total++;
      print_verdict();
   end
endmodule // memory_bus_slave_decode_interface_tb_top
`default_nettype wire
